// [logic/fob_pkg.sv]
package fob_pkg;
    // register byte addresses
    localparam logic [11:0] OFS_KEY      = 12'h000;
    localparam logic [11:0] OFS_BLOCK    = 12'h004;
    localparam logic [11:0] OFS_CTRL     = 12'h008;
    localparam logic [11:0] OFS_RESULT   = 12'h00C;
    localparam logic [11:0] OFS_STATUS   = 12'h010;
    localparam logic [11:0] OFS_IRQ_STAT = 12'h014;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h018;

    // control and interrupt bit positions
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_FCSB_BIT  = 1;
    localparam int IRQ_ERASE_BIT  = 0;
    localparam int IRQ_BAUD_BIT   = 1;

    // reset values
    localparam logic [7:0] KEY_RESET   = 8'h00;
    localparam logic [7:0] BLOCK_RESET = 8'h00;
    localparam logic [1:0] IRQ_RESET   = 2'h0;

    // erase checks and timing
    localparam logic [7:0]  KEY_GOOD     = 8'h5A;
    localparam logic [7:0]  USER_BLOCKS  = 8'h10;
    localparam logic [15:0] ERASE_CYCLES = 16'h0040;

    // mode pin codes
    localparam logic [2:0] MD_BOOT      = 3'h0;
    localparam logic [2:0] MD_USER_PROG = 3'h6;

    // serial link
    localparam logic [3:0]  FRAME_BITS    = 4'hA;
    localparam logic [17:0] BAUD_LOW_BITS = 18'h00009;
    localparam logic [7:0]  SYNC_BYTE     = 8'h00;
    localparam logic [7:0]  CONFIRM_BYTE  = 8'h55;
    localparam logic [7:0]  CMD_ERASE     = 8'h48;
    localparam logic [7:0]  CMD_PROG      = 8'h50;
    localparam logic [7:0]  ERASE_END     = 8'hFF;

    typedef enum logic [1:0] {
        FOB_NORMAL,
        FOB_BOOT,
        FOB_USER_PROG,
        FOB_USER_BOOT
    } fob_mode_t;

    typedef enum logic [2:0] {
        L_IDLE,
        L_MEAS,
        L_SEND,
        L_CONFIRM,
        L_READY
    } fob_link_t;

    typedef enum logic [1:0] {
        A_NONE,
        A_ERASE,
        A_PROG
    } fob_arg_t;

    typedef struct packed {
        logic [2:0] rsv_hi;
        logic       key_err;
        logic       blk_err;
        logic [1:0] rsv_lo;
        logic       fail;
    } fob_result_t;

    typedef struct packed {
        logic       busy;
        logic       locked;
        fob_mode_t  mode;
    } fob_status_t;
endpackage : fob_pkg

// [logic/fob_core.sv]
`timescale 1ns/100ps
`default_nettype none
module fob_core import fob_pkg::*; (
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output var  logic [31:0] o_prdata,
    output var  logic        o_pready,
    output var  logic        o_pslverr,
    input  wire logic        i_flash_write_permit_pin,
    input  wire logic [2:0]  i_mode_select_pin,
    input  wire logic        i_nmi,
    input  wire logic        i_irq_req,
    input  wire logic        i_rxd,
    output var  logic        o_txd,
    output var  fob_mode_t   o_mode,
    output var  logic        o_flash_on,
    output var  logic        o_erase_busy,
    output var  logic [7:0]  o_erase_block,
    output var  logic [7:0]  o_prog_data,
    output var  logic        o_prog_valid,
    output var  logic        o_nmi_taken,
    output var  logic        o_irq_taken,
    output var  logic        o_irq
);
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    function automatic fob_mode_t decode_mode(input logic flash_write_permit_pin, input logic [2:0] md,
                                              input logic nmi);
        decode_mode = FOB_NORMAL;
        if (flash_write_permit_pin && md == MD_BOOT)
            decode_mode = nmi ? FOB_BOOT : FOB_USER_BOOT;
        else if (flash_write_permit_pin && md == MD_USER_PROG)
            decode_mode = FOB_USER_PROG;
    endfunction : decode_mode

    logic        rst_q;
    fob_mode_t   mode;
    logic        fcsb;
    logic [7:0]  key;
    logic [7:0]  block;
    fob_result_t result;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic        busy;
    logic [15:0] erase_cnt;
    logic        erase_done;
    logic        locked;
    logic        lock_evt;
    fob_link_t   lstate;
    fob_arg_t    arg;
    logic [17:0] meas;
    logic [13:0] bit_len;
    logic        host_req;
    logic [7:0]  host_block;
    logic        rx_busy;
    logic        rx_prev;
    logic        rx_valid;
    logic [13:0] rx_cnt;
    logic [3:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic        tx_load;
    logic [9:0]  tx_sh;
    logic [3:0]  tx_left;
    logic [13:0] tx_cnt;

    // mode pins are only looked at on the cycle that follows reset release
    wire fob_mode_t pin_mode = decode_mode(i_flash_write_permit_pin, i_mode_select_pin, i_nmi);
    wire boot      = (mode == FOB_BOOT);
    wire next_fon  = boot || mode == FOB_USER_BOOT || (mode == FOB_USER_PROG && fcsb);

    wire apb_done  = i_psel && i_penable && o_pready;
    wire wr        = apb_done && i_pwrite;
    wire hit_key   = hit(i_paddr, OFS_KEY);
    wire hit_blk   = hit(i_paddr, OFS_BLOCK);
    wire hit_ctrl  = hit(i_paddr, OFS_CTRL);
    wire hit_res   = hit(i_paddr, OFS_RESULT);
    wire hit_stat  = hit(i_paddr, OFS_STATUS);
    wire hit_istat = hit(i_paddr, OFS_IRQ_STAT);
    wire hit_imask = hit(i_paddr, OFS_IRQ_MASK);
    wire mapped    = hit_key | hit_blk | hit_ctrl | hit_res | hit_stat | hit_istat | hit_imask;
    wire fob_status_t status = '{busy: busy, locked: locked, mode: mode};
    wire [31:0] rd_val = hit_key   ? {24'h0, key} :
                         hit_blk   ? {24'h0, block} :
                         hit_ctrl  ? {30'h0, fcsb, 1'b0} :
                         hit_res   ? {24'h0, result} :
                         hit_stat  ? {28'h0, status} :
                         hit_istat ? {30'h0, irq_stat} :
                         hit_imask ? {30'h0, irq_mask} : 32'h0;

    // software erase only counts while the flash is opened for programming
    wire sw_start  = wr && hit_ctrl && i_pwdata[CTRL_START_BIT] && o_flash_on;
    wire start_acc = (sw_start || host_req) && !busy;
    wire [7:0] req_blk = sw_start ? block : host_block;
    wire next_key_err = sw_start && key != KEY_GOOD;
    wire next_blk_err = req_blk >= USER_BLOCKS;
    wire rx_en     = (lstate == L_CONFIRM) || (lstate == L_READY);
    wire tx_busy   = (tx_left != 4'h0);
    wire [1:0] irq_evt = {lock_evt, erase_done};

    always_ff @(posedge i_clock) begin
        rst_q <= i_rst;
        if (i_rst)
            mode <= FOB_NORMAL;
        else if (rst_q)
            mode <= pin_mode;
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= i_psel && i_penable && !o_pready;
            o_prdata  <= rd_val;
            o_pslverr <= i_psel && i_penable && !o_pready && !mapped;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            key      <= KEY_RESET;
            block    <= BLOCK_RESET;
            fcsb     <= 1'b0;
            irq_mask <= IRQ_RESET;
            irq_stat <= IRQ_RESET;
        end else begin
            if (wr && hit_key)
                key <= i_pwdata[7:0];
            if (wr && hit_blk)
                block <= i_pwdata[7:0];
            if (wr && hit_ctrl)
                fcsb <= i_pwdata[CTRL_FCSB_BIT];
            if (wr && hit_imask)
                irq_mask <= i_pwdata[1:0];
            // a new event beats a clearing write in the same cycle
            irq_stat <= (irq_stat & ~((wr && hit_istat) ? i_pwdata[1:0] : 2'h0)) | irq_evt;
        end
    end

    // erase engine: a failed check finishes at once, a good one runs the timer
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            busy          <= 1'b0;
            erase_cnt     <= 16'h0;
            erase_done    <= 1'b0;
            result        <= '0;
            o_erase_block <= 8'h0;
        end else begin
            erase_done <= 1'b0;
            if (start_acc) begin
                if (next_key_err || next_blk_err) begin
                    result     <= '{rsv_hi: 3'h0, key_err: next_key_err, blk_err: next_blk_err,
                                    rsv_lo: 2'h0, fail: 1'b1};
                    erase_done <= 1'b1;
                end else begin
                    busy          <= 1'b1;
                    erase_cnt     <= ERASE_CYCLES;
                    o_erase_block <= req_blk;
                end
            end else if (busy) begin
                erase_cnt <= erase_cnt - 16'h1;
                if (erase_cnt == 16'h1) begin
                    busy       <= 1'b0;
                    erase_done <= 1'b1;
                    result     <= '0;
                end
            end
        end
    end

    // link: bit-rate hunt on the first H'00, answer, confirm, then commands
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            lstate      <= L_IDLE;
            meas        <= 18'h0;
            bit_len     <= 14'h1;
            locked      <= 1'b0;
            lock_evt    <= 1'b0;
            tx_load     <= 1'b0;
            arg         <= A_NONE;
            host_req    <= 1'b0;
            host_block  <= 8'h0;
            o_prog_data <= 8'h0;
            o_prog_valid <= 1'b0;
        end else begin
            lock_evt     <= 1'b0;
            tx_load      <= 1'b0;
            o_prog_valid <= 1'b0;
            if (start_acc && !sw_start)
                host_req <= 1'b0;
            case (lstate)
                L_IDLE: begin
                    if (boot && !i_rxd) begin
                        lstate <= L_MEAS;
                        meas   <= 18'h1;
                    end
                end
                L_MEAS: begin
                    if (!i_rxd) begin
                        meas <= meas + 18'h1;
                    end else begin
                        // start bit plus eight zero bits gave nine bit times of low
                        bit_len <= 14'(meas / BAUD_LOW_BITS);
                        tx_load <= 1'b1;
                        lstate  <= L_SEND;
                    end
                end
                L_SEND: begin
                    if (!tx_busy && !tx_load)
                        lstate <= L_CONFIRM;
                end
                L_CONFIRM: begin
                    if (rx_valid) begin
                        if (rx_sh == CONFIRM_BYTE) begin
                            lstate   <= L_READY;
                            locked   <= 1'b1;
                            lock_evt <= 1'b1;
                        end else begin
                            lstate <= L_IDLE;
                        end
                    end
                end
                L_READY: begin
                    if (rx_valid) begin
                        case (arg)
                            A_NONE: begin
                                if (rx_sh == CMD_ERASE)
                                    arg <= A_ERASE;
                                else if (rx_sh == CMD_PROG)
                                    arg <= A_PROG;
                            end
                            A_ERASE: begin
                                if (rx_sh == ERASE_END) begin
                                    arg <= A_NONE;
                                end else begin
                                    host_req   <= 1'b1;
                                    host_block <= rx_sh;
                                end
                            end
                            A_PROG: begin
                                o_prog_data  <= rx_sh;
                                o_prog_valid <= 1'b1;
                                arg          <= A_NONE;
                            end
                            default: arg <= A_NONE;
                        endcase
                    end
                end
                default: lstate <= L_IDLE;
            endcase
        end
    end

    // receiver: mid-bit sampling at the measured rate, no parity
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            rx_busy  <= 1'b0;
            rx_prev  <= 1'b1;
            rx_valid <= 1'b0;
            rx_cnt   <= 14'h0;
            rx_bit   <= 4'h0;
            rx_sh    <= 8'h0;
        end else begin
            rx_valid <= 1'b0;
            rx_prev  <= i_rxd;
            if (!rx_busy) begin
                if (rx_en && rx_prev && !i_rxd) begin
                    rx_busy <= 1'b1;
                    rx_cnt  <= {1'b0, bit_len[13:1]};
                    rx_bit  <= 4'h0;
                end
            end else if (rx_cnt != 14'h0) begin
                rx_cnt <= rx_cnt - 14'h1;
            end else begin
                rx_cnt <= bit_len - 14'h1;
                rx_bit <= rx_bit + 4'h1;
                if (rx_bit == 4'h0 && i_rxd) begin
                    rx_busy <= 1'b0;
                end else if (rx_bit == FRAME_BITS - 4'h1) begin
                    rx_busy  <= 1'b0;
                    rx_valid <= i_rxd;
                end else if (rx_bit != 4'h0) begin
                    rx_sh <= {i_rxd, rx_sh[7:1]};
                end
            end
        end
    end

    // transmitter: start bit, eight data bits lsb first, one stop bit
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            tx_sh   <= 10'h3FF;
            tx_left <= 4'h0;
            tx_cnt  <= 14'h0;
            o_txd   <= 1'b1;
        end else if (tx_load) begin
            tx_sh   <= {1'b1, SYNC_BYTE, 1'b0};
            tx_left <= FRAME_BITS;
            tx_cnt  <= bit_len - 14'h1;
            o_txd   <= 1'b0;
        end else if (tx_busy) begin
            if (tx_cnt != 14'h0) begin
                tx_cnt <= tx_cnt - 14'h1;
            end else begin
                tx_cnt  <= bit_len - 14'h1;
                tx_left <= tx_left - 4'h1;
                tx_sh   <= {1'b1, tx_sh[9:1]};
                o_txd   <= tx_sh[1];
            end
        end
    end

    // boot mode swallows every request, including our own event line
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_mode       <= FOB_NORMAL;
            o_flash_on   <= 1'b0;
            o_erase_busy <= 1'b0;
            o_nmi_taken  <= 1'b0;
            o_irq_taken  <= 1'b0;
            o_irq        <= 1'b0;
        end else begin
            o_mode       <= mode;
            o_flash_on   <= next_fon;
            o_erase_busy <= busy;
            o_nmi_taken  <= i_nmi && !boot;
            o_irq_taken  <= i_irq_req && !boot;
            o_irq        <= |(irq_stat & irq_mask) && !boot;
        end
    end

    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);

    chk_key_flag: assert property (
        start_acc && sw_start && key != KEY_GOOD |=> erase_done && result.key_err && result.fail)
        else $error("key error not reported");
    chk_block_flag: assert property (
        start_acc && req_blk >= USER_BLOCKS |=> erase_done && result.blk_err)
        else $error("block range error not reported");
    chk_fail_bits: assert property (
        result.rsv_lo == 2'h0 && result.fail == (result.key_err || result.blk_err))
        else $error("result bit layout wrong");
    chk_mode_capture: assert property (
        rst_q && !i_rst |=> mode == $past(pin_mode) ##1 mode == $past(mode))
        else $error("mode not taken at reset release");
    chk_boot_masks_irq: assert property (
        boot |=> !o_nmi_taken && !o_irq_taken && !o_irq)
        else $error("interrupt passed in boot mode");
    chk_ack_after_meas: assert property (
        lstate == L_MEAS && i_rxd |=> tx_load ##1 tx_busy && !o_txd)
        else $error("no answer after rate measurement");
    chk_stop_bit: assert property (
        tx_left == 4'h1 && tx_load == 1'b0 |-> o_txd)
        else $error("stop bit not high");
    chk_result_hold: assert property (
        !start_acc && !(busy && erase_cnt == 16'h1) |=> $stable(result))
        else $error("result changed without erase");
    chk_host_erase: assert property (
        lstate == L_READY && arg == A_ERASE && rx_valid && rx_sh != ERASE_END
        |=> host_req ##[1:2] (busy || erase_done || !host_req))
        else $error("host erase not started");
    chk_erase_length: assert property (
        start_acc && !next_key_err && !next_blk_err |=> busy [*8])
        else $error("erase ended too early");

    cov_lock: cover property (lock_evt);
    cov_erase_ok: cover property (erase_done && !result.fail);
    cov_erase_bad: cover property (erase_done && result.key_err);
    cov_host_prog: cover property (o_prog_valid);
endmodule : fob_core
`default_nettype wire

// [dv/fob_host.sv]
`timescale 1ns/100ps
`default_nettype none
module fob_host #(
    parameter int BIT_CYCLES = 64
) (
    input  wire logic i_clock,
    input  wire logic i_txd,
    output var  logic o_rxd
);
    // bit time is far shorter than a real host rate so the run stays short
    initial o_rxd = 1'h1;

    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'h1, b, 1'h0};
        for (int i = 0; i < 10; i++) begin
            o_rxd <= frame[i];
            repeat (BIT_CYCLES) @(posedge i_clock);
        end
    endtask : send_byte

    task automatic recv_byte(output logic [7:0] b, output logic ok);
        ok = 1'h0;
        b  = 8'h00;
        for (int n = 0; n < 4000 && !ok; n++) begin
            @(posedge i_clock);
            if (i_txd === 1'h0) ok = 1'h1;
        end
        repeat (BIT_CYCLES / 2) @(posedge i_clock);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(posedge i_clock);
            b[i] = i_txd;
        end
        repeat (BIT_CYCLES) @(posedge i_clock);
        if (i_txd !== 1'h1) ok = 1'h0;
        // the device only listens again once its own stop bit is over
        repeat (BIT_CYCLES) @(posedge i_clock);
    endtask : recv_byte
endmodule : fob_host
`default_nettype wire

// [dv/fob_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module flash_onboard_mode_and_erase_status_bench import fob_pkg::*;;
    logic        i_clock   = 1'h0;
    logic        i_rst     = 1'h1;
    logic        psel      = 1'h0;
    logic        penable   = 1'h0;
    logic        pwrite    = 1'h0;
    logic [11:0] paddr     = 12'h000;
    logic [31:0] pwdata    = 32'h0;
    logic        flash_write_permit_pin       = 1'h1;
    logic [2:0]  md        = 3'h6;
    logic        nmi       = 1'h1;
    logic        irq_req   = 1'h0;
    logic [7:0]  seen_prog = 8'h00;
    logic [31:0] prdata;
    logic        pready, pslverr, rxd, txd, flash_on, busy, prog_valid;
    logic        nmi_taken, irq_taken, irq;
    logic [7:0]  erase_block, prog_data;
    fob_mode_t   mode;
    int          failures    = 0;
    int          comparisons = 0;

    always #12.5 i_clock = ~i_clock;

    fob_core i_dut (.i_clock(i_clock), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_flash_write_permit_pin(flash_write_permit_pin),
        .i_mode_select_pin(md), .i_nmi(nmi), .i_irq_req(irq_req), .i_rxd(rxd), .o_txd(txd),
        .o_mode(mode), .o_flash_on(flash_on), .o_erase_busy(busy),
        .o_erase_block(erase_block), .o_prog_data(prog_data), .o_prog_valid(prog_valid),
        .o_nmi_taken(nmi_taken), .o_irq_taken(irq_taken), .o_irq(irq));

    fob_host #(.BIT_CYCLES(64)) i_host (.i_clock(i_clock), .i_txd(txd), .o_rxd(rxd));

    // the valid strobe lasts one cycle, so it is caught here rather than polled
    always @(posedge i_clock) if (prog_valid === 1'h1) seen_prog <= prog_data;

    task automatic tally_and_finish();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    task automatic give_up();
        failures++;
        tally_and_finish();
    endtask : give_up

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge i_clock);
        psel    <= 1'h1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge i_clock);
        penable <= 1'h1;
        do begin
            @(posedge i_clock);
            n++;
            if (n > 20) give_up();
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'h1, a, d, r, e);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic err_exp);
        logic [31:0] r;
        logic        e;
        apb(1'h0, a, 32'h0, r, e);
        check(r, exp);
        check({31'h0, e}, {31'h0, err_exp});
    endtask : rd_chk

    task automatic restart(input logic [7:0] t);
        @(posedge i_clock);
        i_rst <= 1'h1;
        flash_write_permit_pin   <= t[7];
        md    <= t[6:4];
        nmi   <= t[3];
        repeat (4) @(posedge i_clock);
        i_rst <= 1'h0;
        repeat (3) @(posedge i_clock);
    endtask : restart

    task automatic wait_busy(input logic lvl, input int lim);
        for (int n = 0; busy !== lvl; n++) begin
            @(posedge i_clock);
            if (n > lim) give_up();
        end
        repeat (2) @(posedge i_clock);
    endtask : wait_busy

    // pins {permit, mode[2:0], nmi}, then flash-on and mode code expected
    task automatic s_modes();
        logic [7:0] tbl [6] = '{8'h8D, 8'h87, 8'hE2, 8'hEA, 8'h08, 8'hF8};
        irq_req <= 1'h1;
        foreach (tbl[i]) begin
            restart(tbl[i]);
            check({30'h0, mode}, {30'h0, tbl[i][1:0]});
            check({31'h0, flash_on}, {31'h0, tbl[i][2]});
            check({31'h0, irq_taken}, {31'h0, tbl[i][1:0] != 2'h1});
            check({31'h0, nmi_taken}, {31'h0, tbl[i][3] && tbl[i][1:0] != 2'h1});
            rd_chk(OFS_STATUS, {30'h0, tbl[i][1:0]}, 1'h0);
        end
        irq_req <= 1'h0;
    endtask : s_modes

    // {key, block, result}: block 16 is the first one out of range
    task automatic s_erase();
        logic [23:0] tbl [4] = '{24'h000311, 24'h5A1009, 24'h001019, 24'h5A0F00};
        restart(8'hEA);
        rd_chk(OFS_KEY, 32'h0, 1'h0);
        rd_chk(OFS_BLOCK, 32'h0, 1'h0);
        rd_chk(OFS_IRQ_MASK, 32'h0, 1'h0);
        rd_chk(12'h01C, 32'h0, 1'h1);
        wr(OFS_CTRL, 32'h2);
        repeat (2) @(posedge i_clock);
        check({31'h0, flash_on}, 32'h1);
        foreach (tbl[i]) begin
            wr(OFS_KEY, {24'h0, tbl[i][23:16]});
            wr(OFS_BLOCK, {24'h0, tbl[i][15:8]});
            wr(OFS_CTRL, 32'h3);
            if (tbl[i][7:0] == 8'h00) begin
                wait_busy(1'h1, 10);
                wait_busy(1'h0, 200);
            end
            rd_chk(OFS_RESULT, {24'h0, tbl[i][7:0]}, 1'h0);
        end
        check({24'h0, erase_block}, 32'h0F);
        wr(OFS_RESULT, 32'hFF);
        rd_chk(OFS_RESULT, 32'h0, 1'h0);
        check({31'h0, irq}, 32'h0);
        wr(OFS_IRQ_MASK, 32'h1);
        repeat (2) @(posedge i_clock);
        check({31'h0, irq}, 32'h1);
        wr(OFS_IRQ_STAT, 32'h1);
        repeat (2) @(posedge i_clock);
        check({31'h0, irq}, 32'h0);
        rd_chk(OFS_IRQ_STAT, 32'h0, 1'h0);
    endtask : s_erase

    task automatic s_boot();
        logic [7:0] b;
        logic       ok;
        restart(8'h8D);
        wr(OFS_IRQ_MASK, 32'h3);
        irq_req <= 1'h1;
        fork
            i_host.send_byte(SYNC_BYTE);
            i_host.recv_byte(b, ok);
        join
        check({31'h0, ok}, 32'h1);
        check({24'h0, b}, 32'h00);
        i_host.send_byte(CONFIRM_BYTE);
        rd_chk(OFS_STATUS, 32'h5, 1'h0);
        rd_chk(OFS_IRQ_STAT, 32'h2, 1'h0);
        check({30'h0, irq, irq_taken}, 32'h0);
        irq_req <= 1'h0;
        i_host.send_byte(CMD_ERASE);
        i_host.send_byte(8'h02);
        wait_busy(1'h1, 1000);
        wait_busy(1'h0, 200);
        check({24'h0, erase_block}, 32'h02);
        i_host.send_byte(ERASE_END);
        i_host.send_byte(CMD_PROG);
        i_host.send_byte(8'hA3);
        repeat (8) @(posedge i_clock);
        check({24'h0, seen_prog}, 32'hA3);
    endtask : s_boot

    initial begin
        repeat (4) @(posedge i_clock);
        i_rst <= 1'h0;
        s_modes();
        s_erase();
        s_boot();
        tally_and_finish();
    end
endmodule : flash_onboard_mode_and_erase_status_bench
`default_nettype wire
